//--- verilog/pbps_pkg.sv
package pbps_pkg;

  // Operating mode codes as presented on the mode input.
  localparam logic [2:0] PBPS_MODE_1 = 3'h1;
  localparam logic [2:0] PBPS_MODE_2 = 3'h2;
  localparam logic [2:0] PBPS_MODE_4 = 3'h4;
  localparam logic [2:0] PBPS_MODE_7 = 3'h7;

  // Timer mode field codes.
  localparam logic [3:0] PBPS_TMD_NORMAL = 4'h0;
  localparam logic [3:0] PBPS_TMD_PWM1 = 4'h2;
  localparam logic [3:0] PBPS_TMD_PWM2 = 4'h3;
  localparam logic [1:0] PBPS_TMD_PHASE_HI = 2'h1;

  // Counter clear codes for the two-bit channels.
  localparam logic [1:0] PBPS_CLR_A = 2'h1;
  localparam logic [1:0] PBPS_CLR_B = 2'h2;

  // Channel 6 counter clear codes per pin.
  localparam logic [2:0] PBPS_CLR6_A = 3'h1;
  localparam logic [2:0] PBPS_CLR6_B = 3'h2;
  localparam logic [2:0] PBPS_CLR6_C = 3'h5;
  localparam logic [2:0] PBPS_CLR6_D = 3'h6;

  // Prescaler codes that pick an external clock pin.
  localparam logic [2:0] PBPS_PSC_E = 3'h4;
  localparam logic [2:0] PBPS_PSC_F = 3'h5;
  localparam logic [2:0] PBPS_PSC_H = 3'h7;

  // I/O select patterns.
  localparam logic [1:0] PBPS_IOSEL_CAPT = 2'h2;
  localparam logic [1:0] PBPS_IOSEL_LO_OFF = 2'h0;

  // Pin positions within port B.
  localparam int PBPS_PIN_A6 = 0;
  localparam int PBPS_PIN_B6 = 1;
  localparam int PBPS_PIN_C6 = 2;
  localparam int PBPS_PIN_D6 = 3;
  localparam int PBPS_PIN_A7 = 4;
  localparam int PBPS_PIN_B7 = 5;
  localparam int PBPS_PIN_A8 = 6;
  localparam int PBPS_PIN_B8 = 7;

  // Reset values of the direction and pull-up registers.
  localparam logic [7:0] PBPS_DIR_RESET = 8'h00;
  localparam logic [7:0] PBPS_PU_RESET = 8'h00;

  // High address bits carried by port B: pin 7 is A15, pin 0 is A8.
  localparam int PBPS_ADDR_LSB = 8;

endpackage : pbps_pkg

//--- verilog/pbps_cc_if.sv
`timescale 1ns/1ns
// One capture/compare pin's decoded function, shared by all eight pins.
interface pbps_cc_if;
  logic [3:0] tmode;
  logic [3:0] iosel;
  logic pwm1_pin;
  logic pwm2_block;
  logic capt_01xx_ok;
  logic capt_iosel_bit3;
  logic out_en;
  logic capt_en;
  modport dec (
    input tmode, iosel, pwm1_pin, pwm2_block, capt_01xx_ok,
    input capt_iosel_bit3,
    output out_en, capt_en
  );
  modport top (
    output tmode, iosel, pwm1_pin, pwm2_block, capt_01xx_ok,
    output capt_iosel_bit3,
    input out_en, capt_en
  );
endinterface : pbps_cc_if

//--- verilog/pbps_cc_decode.sv
`timescale 1ns/1ns
// Decodes whether one capture/compare pin drives a timer output or
// takes a capture input.
module pbps_cc_decode
  import pbps_pkg::*;
(
  pbps_cc_if.dec cc
);

  logic oc_sel;
  logic io_active;

  always_comb begin
    oc_sel = (cc.iosel[3] == 1'b0) && (cc.iosel[1:0] != PBPS_IOSEL_LO_OFF);
    io_active = (cc.iosel[1:0] != PBPS_IOSEL_LO_OFF);
    cc.out_en = 1'b0;
    if (cc.tmode == PBPS_TMD_NORMAL) begin
      cc.out_en = oc_sel;
    end
    else if (cc.tmode[3:2] == PBPS_TMD_PHASE_HI && cc.capt_01xx_ok) begin
      cc.out_en = oc_sel;
    end
    else if (cc.tmode == PBPS_TMD_PWM1) begin
      cc.out_en = cc.pwm1_pin && io_active;
    end
    else if (cc.tmode == PBPS_TMD_PWM2) begin
      cc.out_en = io_active && !cc.pwm2_block;
    end
    cc.capt_en = 1'b0;
    if (cc.tmode == PBPS_TMD_NORMAL ||
        (cc.capt_01xx_ok && cc.tmode[3:2] == PBPS_TMD_PHASE_HI)) begin
      cc.capt_en = cc.capt_iosel_bit3 ? cc.iosel[3] :
                   (cc.iosel[3:2] == PBPS_IOSEL_CAPT);
    end
  end

endmodule : pbps_cc_decode

//--- verilog/pbps_port_b.sv
`timescale 1ns/1ns
// Overview of operation
// - Each pin shares GPIO, address A15..A8 and timer functions.
// - Modes 1 and 2 drive address on every pin regardless of direction.
// - Mode 4 or 7 expanded: direction 1 address out, 0 input.
// - Mode 7 single chip: timer output wins, else direction picks GPIO.
// - Normal mode compare output for select 0001-0011 and 0101-0111.
// - PWM mode 1: A or C pin outputs, paired B or D disabled.
// - PWM mode 2 output unless clear source is the pin's own register.
// - Channel 6 clear codes 001 A, 010 B, 101 C, 110 D.
// - Channel 6 buffer mode disables C and D timer outputs.
// - Channel 7/8 capture in normal or 01xx modes per select.
// - Channel 6 capture only in normal mode with select 10xx.
// - Pin 7 is clock H on prescaler 111 or phase counting.
// - Pin 5 is clock G on 111, 101 or phase counting.
// - Pin 3 is clock F on prescaler 101 or phase counting.
// - Pin 2 is clock E on prescaler 100 or phase counting.
// - Pull-ups usable only in modes 4 and 7, per pin.
// - Pull-up on when direction 0 and pull-up control 1.
// - Pull-ups off in reset, hardware standby and modes 1, 2.
// - Direction bits write-only, reset to zero.
module pbps_port_b
  import pbps_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_mode,
  input wire logic i_ext_expand_enable,
  input wire logic i_hw_standby,
  input wire logic i_dir_we,
  input wire logic [7:0] i_dir_wdata,
  input wire logic i_pullup_we,
  input wire logic [7:0] i_pullup_wdata,
  input wire logic [7:0] i_gpio_out,
  input wire logic [7:0] i_addr_hi,
  input wire logic [7:0] i_timer_mode_reg_ch6,
  input wire logic [7:0] i_timer_mode_reg_ch7,
  input wire logic [7:0] i_timer_mode_reg_ch8,
  input wire logic [7:0] i_timer_io_ctrl_hi_ch6,
  input wire logic [7:0] i_timer_io_ctrl_lo_ch6,
  input wire logic [7:0] i_timer_io_ctrl_ch7,
  input wire logic [7:0] i_timer_io_ctrl_ch8,
  input wire logic [2:0] i_counter_clear_sel_ch6,
  input wire logic [1:0] i_counter_clear_sel_ch7,
  input wire logic [1:0] i_counter_clear_sel_ch8,
  input wire logic [2:0] i_prescaler_sel_ch6,
  input wire logic [2:0] i_prescaler_sel_ch7,
  input wire logic [2:0] i_prescaler_sel_ch8,
  input wire logic [2:0] i_prescaler_sel_ch9,
  input wire logic [2:0] i_prescaler_sel_ch10,
  input wire logic [2:0] i_prescaler_sel_ch11,
  input wire logic i_phase_cnt_ch7_ch11,
  input wire logic i_phase_cnt_ch8_ch10,
  input wire logic [7:0] i_timer_out,
  input wire logic [7:0] i_pin_in,
  output logic [7:0] o_pin_out,
  output logic [7:0] o_pin_oe,
  output logic [7:0] o_pullup_on,
  output logic [7:0] o_capture_in_en,
  output logic [7:0] o_capture_in,
  output logic o_ext_timer_clk_e,
  output logic o_ext_timer_clk_f,
  output logic o_ext_timer_clk_g,
  output logic o_ext_timer_clk_h,
  output logic [7:0] o_pin_state
);

  logic [7:0] portb_direction_reg;
  logic [7:0] portb_direction_next;
  logic [7:0] portb_pullup_ctrl_reg;
  logic [7:0] portb_pullup_ctrl_next;
  logic [7:0] pin_sync1_reg;
  logic [7:0] pin_sync1_next;
  logic [7:0] pin_sync2_reg;
  logic [7:0] pin_sync2_next;
  logic [7:0] pin_out_reg;
  logic [7:0] pin_out_next;
  logic [7:0] pin_oe_reg;
  logic [7:0] pin_oe_next;
  logic [7:0] pullup_reg;
  logic [7:0] pullup_next;
  logic [7:0] capt_en_reg;
  logic [7:0] capt_en_next;
  logic [3:0] clk_sel_reg;
  logic [3:0] clk_sel_next;

  logic [7:0] tmr_oe;
  logic [7:0] tmr_capt;
  logic [3:0] tmode [8];
  logic [3:0] iosel [8];
  logic [7:0] pwm1_pin;
  logic [7:0] pwm2_block;
  logic [7:0] capt_01xx_ok;
  logic [7:0] capt_bit3;
  logic buf6;
  logic mode_bus;
  logic mode_exp;
  logic mode_single;
  logic pu_mode;

  pbps_cc_if cc_bus [8] ();

  // Per-pin channel, select field and qualifiers.
  always_comb begin
    tmode[PBPS_PIN_A6] = i_timer_mode_reg_ch6[3:0];
    tmode[PBPS_PIN_B6] = i_timer_mode_reg_ch6[3:0];
    tmode[PBPS_PIN_C6] = i_timer_mode_reg_ch6[3:0];
    tmode[PBPS_PIN_D6] = i_timer_mode_reg_ch6[3:0];
    tmode[PBPS_PIN_A7] = i_timer_mode_reg_ch7[3:0];
    tmode[PBPS_PIN_B7] = i_timer_mode_reg_ch7[3:0];
    tmode[PBPS_PIN_A8] = i_timer_mode_reg_ch8[3:0];
    tmode[PBPS_PIN_B8] = i_timer_mode_reg_ch8[3:0];
    iosel[PBPS_PIN_A6] = i_timer_io_ctrl_hi_ch6[3:0];
    iosel[PBPS_PIN_B6] = i_timer_io_ctrl_hi_ch6[7:4];
    iosel[PBPS_PIN_C6] = i_timer_io_ctrl_lo_ch6[3:0];
    iosel[PBPS_PIN_D6] = i_timer_io_ctrl_lo_ch6[7:4];
    iosel[PBPS_PIN_A7] = i_timer_io_ctrl_ch7[3:0];
    iosel[PBPS_PIN_B7] = i_timer_io_ctrl_ch7[7:4];
    iosel[PBPS_PIN_A8] = i_timer_io_ctrl_ch8[3:0];
    iosel[PBPS_PIN_B8] = i_timer_io_ctrl_ch8[7:4];
    buf6 = i_timer_mode_reg_ch6[4] | i_timer_mode_reg_ch6[5];
    // A or C pin carries PWM
    pwm1_pin = 8'h00;
    pwm1_pin[PBPS_PIN_A6] = 1'b1;
    pwm1_pin[PBPS_PIN_C6] = 1'b1;
    pwm1_pin[PBPS_PIN_A7] = 1'b1;
    pwm1_pin[PBPS_PIN_A8] = 1'b1;
    pwm2_block = 8'h00;
    pwm2_block[PBPS_PIN_A6] = (i_counter_clear_sel_ch6 == PBPS_CLR6_A);
    pwm2_block[PBPS_PIN_B6] = (i_counter_clear_sel_ch6 == PBPS_CLR6_B);
    pwm2_block[PBPS_PIN_C6] = (i_counter_clear_sel_ch6 == PBPS_CLR6_C);
    pwm2_block[PBPS_PIN_D6] = (i_counter_clear_sel_ch6 == PBPS_CLR6_D);
    // channel 7 and 8 own-clear codes
    pwm2_block[PBPS_PIN_A7] = (i_counter_clear_sel_ch7 == PBPS_CLR_A);
    pwm2_block[PBPS_PIN_B7] = (i_counter_clear_sel_ch7 == PBPS_CLR_B);
    pwm2_block[PBPS_PIN_A8] = (i_counter_clear_sel_ch8 == PBPS_CLR_A);
    pwm2_block[PBPS_PIN_B8] = (i_counter_clear_sel_ch8 == PBPS_CLR_B);
    // channel 6 capture only in normal mode
    capt_01xx_ok = 8'hf0;
    // channel 8 uses bit 3 alone
    capt_bit3 = 8'h00;
    capt_bit3[PBPS_PIN_A8] = 1'b1;
    capt_bit3[PBPS_PIN_B8] = 1'b1;
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_cc
      assign cc_bus[g].tmode = tmode[g];
      assign cc_bus[g].iosel = iosel[g];
      assign cc_bus[g].pwm1_pin = pwm1_pin[g];
      assign cc_bus[g].pwm2_block = pwm2_block[g];
      assign cc_bus[g].capt_01xx_ok = capt_01xx_ok[g];
      assign cc_bus[g].capt_iosel_bit3 = capt_bit3[g];
      assign tmr_capt[g] = cc_bus[g].capt_en;
      pbps_cc_decode u_dec (
        .cc(cc_bus[g])
      );
    end
  endgenerate

  always_comb begin
    tmr_oe = 8'h00;
    for (int i = 0; i < 8; i++) begin
      tmr_oe[i] = cc_bus_oe(i);
    end
    // buffer mode kills C and D
    if (buf6) begin
      tmr_oe[PBPS_PIN_C6] = 1'b0;
      tmr_oe[PBPS_PIN_D6] = 1'b0;
    end
  end

  function automatic logic cc_bus_oe(input int idx);
    logic r;
    r = 1'b0;
    case (idx)
      0: r = cc_bus[0].out_en;
      1: r = cc_bus[1].out_en;
      2: r = cc_bus[2].out_en;
      3: r = cc_bus[3].out_en;
      4: r = cc_bus[4].out_en;
      5: r = cc_bus[5].out_en;
      6: r = cc_bus[6].out_en;
      7: r = cc_bus[7].out_en;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : cc_bus_oe

  // Registers, pin function and derived outputs.
  always_comb begin
    mode_bus = (i_mode == PBPS_MODE_1) || (i_mode == PBPS_MODE_2);
    mode_exp = (i_mode == PBPS_MODE_4) ||
               ((i_mode == PBPS_MODE_7) && i_ext_expand_enable);
    mode_single = (i_mode == PBPS_MODE_7) && !i_ext_expand_enable;
    // pull-ups only in modes 4 and 7
    pu_mode = (i_mode == PBPS_MODE_4) || (i_mode == PBPS_MODE_7);
    portb_direction_next = i_dir_we ? i_dir_wdata : portb_direction_reg;
    portb_pullup_ctrl_next = i_pullup_we ? i_pullup_wdata :
                             portb_pullup_ctrl_reg;
    pin_sync1_next = i_pin_in;
    pin_sync2_next = pin_sync1_reg;
    pin_out_next = i_gpio_out;
    pin_oe_next = portb_direction_reg;
    capt_en_next = 8'h00;
    if (mode_bus) begin
      pin_out_next = i_addr_hi;
      pin_oe_next = 8'hff;
    end
    else if (mode_exp) begin
      pin_out_next = i_addr_hi;
      pin_oe_next = portb_direction_reg;
    end
    else if (mode_single) begin
      for (int i = 0; i < 8; i++) begin
        if (tmr_oe[i]) begin
          pin_out_next[i] = i_timer_out[i];
          pin_oe_next[i] = 1'b1;
        end
      end
      capt_en_next = tmr_capt & ~tmr_oe;
    end
    // pull-up on for input with control set
    // off in standby and bus modes
    pullup_next = (pu_mode && !i_hw_standby) ?
                  (~portb_direction_reg & portb_pullup_ctrl_reg) : 8'h00;
    clk_sel_next[3] = (i_prescaler_sel_ch6 == PBPS_PSC_H) ||
                      (i_prescaler_sel_ch11 == PBPS_PSC_H) ||
                      i_phase_cnt_ch8_ch10;
    clk_sel_next[2] = (i_prescaler_sel_ch6 == PBPS_PSC_H) ||
                      (i_prescaler_sel_ch8 == PBPS_PSC_H) ||
                      (i_prescaler_sel_ch10 == PBPS_PSC_F) ||
                      (i_prescaler_sel_ch11 == PBPS_PSC_F) ||
                      i_phase_cnt_ch8_ch10;
    clk_sel_next[1] = (i_prescaler_sel_ch6 == PBPS_PSC_F) ||
                      (i_prescaler_sel_ch7 == PBPS_PSC_F) ||
                      (i_prescaler_sel_ch8 == PBPS_PSC_F) ||
                      i_phase_cnt_ch7_ch11;
    clk_sel_next[0] = (i_prescaler_sel_ch6 == PBPS_PSC_E) ||
                      (i_prescaler_sel_ch7 == PBPS_PSC_E) ||
                      (i_prescaler_sel_ch8 == PBPS_PSC_E) ||
                      (i_prescaler_sel_ch9 == PBPS_PSC_E) ||
                      (i_prescaler_sel_ch10 == PBPS_PSC_E) ||
                      (i_prescaler_sel_ch11 == PBPS_PSC_E) ||
                      i_phase_cnt_ch7_ch11;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      portb_direction_reg <= PBPS_DIR_RESET;
      portb_pullup_ctrl_reg <= PBPS_PU_RESET;
      pin_sync1_reg <= 8'h00;
      pin_sync2_reg <= 8'h00;
      pin_out_reg <= 8'h00;
      pin_oe_reg <= 8'h00;
      pullup_reg <= 8'h00;
      capt_en_reg <= 8'h00;
      clk_sel_reg <= 4'h0;
    end
    else begin
      portb_direction_reg <= portb_direction_next;
      portb_pullup_ctrl_reg <= portb_pullup_ctrl_next;
      pin_sync1_reg <= pin_sync1_next;
      pin_sync2_reg <= pin_sync2_next;
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
      pullup_reg <= pullup_next;
      capt_en_reg <= capt_en_next;
      clk_sel_reg <= clk_sel_next;
    end
  end

  // Pull-ups are cut while reset is high, not only on the next edge.
  assign o_pin_out = pin_out_reg;
  assign o_pin_oe = pin_oe_reg;
  assign o_pullup_on = i_rst ? 8'h00 : pullup_reg;
  assign o_capture_in_en = capt_en_reg;
  assign o_capture_in = pin_sync2_reg & capt_en_reg;
  // External clocks follow the synced pin in every mode, gated only by the clock select.
  assign o_ext_timer_clk_e = clk_sel_reg[0] & pin_sync2_reg[2];
  assign o_ext_timer_clk_f = clk_sel_reg[1] & pin_sync2_reg[3];
  assign o_ext_timer_clk_g = clk_sel_reg[2] & pin_sync2_reg[5];
  assign o_ext_timer_clk_h = clk_sel_reg[3] & pin_sync2_reg[7];
  assign o_pin_state = pin_sync2_reg;

endmodule : pbps_port_b

//--- tb/pbps_port_b_sva.sv
`timescale 1ns/1ns
module pbps_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_mode,
  input wire logic i_ext_expand_enable,
  input wire logic i_hw_standby,
  input wire logic [7:0] i_addr_hi,
  input wire logic [7:0] i_timer_out,
  input wire logic [7:0] i_timer_mode_reg_ch8,
  input wire logic [7:0] i_timer_io_ctrl_ch8,
  input wire logic [2:0] i_prescaler_sel_ch9,
  input wire logic [7:0] i_pin_in,
  input wire logic [7:0] o_pin_out,
  input wire logic [7:0] o_pin_oe,
  input wire logic [7:0] o_pullup_on,
  input wire logic [7:0] o_capture_in_en,
  input wire logic [7:0] o_capture_in,
  input wire logic o_ext_timer_clk_e
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_addr_mode12:
  assert property (!$past(i_rst) && (i_mode == 3'h1 || i_mode == 3'h2)
    |=> o_pin_oe == 8'hff && o_pin_out == $past(i_addr_hi))
    else $error("address not driven in mode 1 or 2");
  chk_pu_reset:
  assert property (disable iff (1'b0) i_rst |-> o_pullup_on == 8'h00)
    else $error("pull-up on during reset");
  chk_pu_standby:
  assert property (i_hw_standby |=> o_pullup_on == 8'h00)
    else $error("pull-up on in hardware standby");
  chk_pu_input:
  assert property ($past(i_mode) == 3'h4 |-> (o_pullup_on & o_pin_oe) == 8'h00)
    else $error("pull-up on a driven pin");
  chk_capt_gate:
  assert property (!$past(i_rst) && !$past(i_rst, 2)
    |-> o_capture_in == ($past(i_pin_in, 2) & o_capture_in_en))
    else $error("capture input does not follow the synced pin");
  chk_capt_mode:
  assert property (!(i_mode == 3'h7 && !i_ext_expand_enable)
    |=> o_capture_in_en == 8'h00)
    else $error("capture enabled outside single-chip mode");
  chk_cmp_out:
  assert property (!$past(i_rst) && i_mode == 3'h7 && !i_ext_expand_enable
    && i_timer_mode_reg_ch8[3:0] == 4'h0 && i_timer_io_ctrl_ch8[3:0] == 4'h1
    |=> o_pin_oe[6] && o_pin_out[6] == $past(i_timer_out[6]))
    else $error("compare output missing on pin 6");
  chk_clk_e_on:
  assert property ((i_prescaler_sel_ch9 == 3'h4 && i_pin_in[2])[*4]
    |-> o_ext_timer_clk_e)
    else $error("clock E not passed");
endmodule : pbps_chk

bind pbps_port_b pbps_chk u_chk (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_mode(i_mode),
  .i_ext_expand_enable(i_ext_expand_enable),
  .i_hw_standby(i_hw_standby),
  .i_addr_hi(i_addr_hi),
  .i_timer_out(i_timer_out),
  .i_timer_mode_reg_ch8(i_timer_mode_reg_ch8),
  .i_timer_io_ctrl_ch8(i_timer_io_ctrl_ch8),
  .i_prescaler_sel_ch9(i_prescaler_sel_ch9),
  .i_pin_in(i_pin_in),
  .o_pin_out(o_pin_out),
  .o_pin_oe(o_pin_oe),
  .o_pullup_on(o_pullup_on),
  .o_capture_in_en(o_capture_in_en),
  .o_capture_in(o_capture_in),
  .o_ext_timer_clk_e(o_ext_timer_clk_e)
);

//--- tb/pbps_tmr_model.sv
`timescale 1ns/1ns
// Stands in for the timer unit and the external address source.
module pbps_tmr_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_step,
  output logic [7:0] o_timer_out,
  output logic [7:0] o_addr_hi
);
  // Values move only on a step, so the bench always knows what is shown.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_timer_out <= 8'h96;
      o_addr_hi <= 8'h3c;
    end else if (i_step) begin
      o_timer_out <= o_timer_out ^ o_addr_hi ^ 8'h5b;
      o_addr_hi <= o_addr_hi + 8'h35;
    end
  end
endmodule : pbps_tmr_model

//--- tb/tb_pbps_port_b.sv
`timescale 1ns/1ns
module tb_pbps_port_b;
  import pbps_pkg::*;
  logic i_clk, i_rst, i_ext_expand_enable, i_hw_standby, i_dir_we, step;
  logic i_pullup_we, i_phase_cnt_ch7_ch11, i_phase_cnt_ch8_ch10;
  logic [2:0] i_mode, i_counter_clear_sel_ch6, i_prescaler_sel_ch6;
  logic [2:0] i_prescaler_sel_ch7, i_prescaler_sel_ch8, i_prescaler_sel_ch9;
  logic [2:0] i_prescaler_sel_ch10, i_prescaler_sel_ch11;
  logic [1:0] i_counter_clear_sel_ch7, i_counter_clear_sel_ch8;
  logic [7:0] i_dir_wdata, i_pullup_wdata, i_gpio_out, i_addr_hi, i_pin_in;
  logic [7:0] i_timer_mode_reg_ch6, i_timer_mode_reg_ch7, i_timer_out;
  logic [7:0] i_timer_mode_reg_ch8, i_timer_io_ctrl_hi_ch6;
  logic [7:0] i_timer_io_ctrl_lo_ch6, i_timer_io_ctrl_ch7, i_timer_io_ctrl_ch8;
  logic [7:0] o_pin_out, o_pin_oe, o_pullup_on, o_capture_in_en;
  logic [7:0] o_capture_in, o_pin_state;
  logic o_ext_timer_clk_e, o_ext_timer_clk_f;
  logic o_ext_timer_clk_g, o_ext_timer_clk_h;
  logic [2:0] ml [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
  int mismatches, total_checks, dir, pu;

  pbps_port_b DUT (.*);
  pbps_tmr_model u_tmr (.i_clk(i_clk), .i_rst(i_rst), .i_step(step),
    .o_timer_out(i_timer_out), .o_addr_hi(i_addr_hi));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic apply(input logic [2:0] m, input logic x, input logic h);
    @(posedge i_clk);
    dir = $urandom & 255;
    pu = $urandom & 255;
    i_mode <= m;
    i_ext_expand_enable <= x;
    i_hw_standby <= h;
    i_dir_we <= 1'b1;
    i_dir_wdata <= dir[7:0];
    i_pullup_we <= 1'b1;
    i_pullup_wdata <= pu[7:0];
    i_gpio_out <= 8'($urandom);
    i_pin_in <= 8'($urandom);
    step <= 1'b1;
  endtask : apply

  task automatic settle;
    @(posedge i_clk);
    step <= 1'b0;
    i_dir_we <= 1'b0;
    i_pullup_we <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
  endtask : settle

  task automatic cmp(input int tm, input int ce);
    int oe, po, pe;
    oe = dir | tm;
    po = (i_gpio_out & dir & ~tm) | (i_timer_out & tm);
    pe = (i_mode == 3'h4 || i_mode == 3'h7) ? pu & ~dir : 0;
    if (i_mode == 3'h1 || i_mode == 3'h2) begin
      oe = 255;
      po = i_addr_hi;
    end else if (i_mode == 3'h4 || i_ext_expand_enable) begin
      po = i_addr_hi & dir;
    end
    if (i_hw_standby) pe = 0;
    chk(o_pin_oe, oe[7:0]);
    chk(o_pin_out & o_pin_oe, po[7:0] & oe[7:0]);
    chk(o_pullup_on & ~tm[7:0], pe[7:0] & ~tm[7:0]);
    chk(o_capture_in_en, ce[7:0]);
    chk(o_capture_in, i_pin_in & ce[7:0]);
    chk(o_pin_state, i_pin_in);
  endtask : cmp

  task automatic tcase(input logic [7:0] t6, h6, l6, input logic [2:0] c6,
      input logic [7:0] t78, io78, input logic [1:0] c78, input int tm, ce);
    apply(3'h7, 1'b0, 1'b0);
    i_timer_mode_reg_ch6 <= t6;
    i_timer_io_ctrl_hi_ch6 <= h6;
    i_timer_io_ctrl_lo_ch6 <= l6;
    i_counter_clear_sel_ch6 <= c6;
    {i_timer_mode_reg_ch7, i_timer_mode_reg_ch8} <= {t78, t78};
    {i_timer_io_ctrl_ch7, i_timer_io_ctrl_ch8} <= {io78, io78};
    {i_counter_clear_sel_ch7, i_counter_clear_sel_ch8} <= {c78, c78};
    settle;
    cmp(tm, ce);
  endtask : tcase

  task automatic clk_case(input int i);
    int r, e, f, g, h;
    logic [2:0] p [6];
    r = $urandom;
    @(posedge i_clk);
    {i_prescaler_sel_ch6, i_prescaler_sel_ch7, i_prescaler_sel_ch8} <= r[8:0];
    {i_prescaler_sel_ch10, i_prescaler_sel_ch11} <= r[14:9];
    i_prescaler_sel_ch9 <= i[2:0];
    i_phase_cnt_ch7_ch11 <= (i == 13);
    i_phase_cnt_ch8_ch10 <= (i == 14);
    i_pin_in <= 8'hff;
    settle;
    p = '{i_prescaler_sel_ch6, i_prescaler_sel_ch7, i_prescaler_sel_ch8,
      i_prescaler_sel_ch9, i_prescaler_sel_ch10, i_prescaler_sel_ch11};
    e = i_phase_cnt_ch7_ch11;
    f = e;
    foreach (p[k]) begin
      e |= (p[k] == 3'h4);
      f |= (k < 3 && p[k] == 3'h5);
    end
    g = p[0] == 3'h7 || p[2] == 3'h7 || p[4] == 3'h5 || p[5] == 3'h5;
    h = p[0] == 3'h7 || p[5] == 3'h7;
    g |= i_phase_cnt_ch8_ch10;
    h |= i_phase_cnt_ch8_ch10;
    chk(8'({o_ext_timer_clk_e, o_ext_timer_clk_f, o_ext_timer_clk_g,
      o_ext_timer_clk_h}), 8'({e[0], f[0], g[0], h[0]}));
  endtask : clk_case

  initial begin
    repeat (3000) @(posedge i_clk);
    mismatches++;
    stop_test;
  end

  initial begin
    i_rst = 1'b1;
    {i_mode, i_ext_expand_enable, i_hw_standby, i_dir_we, step} = '0;
    {i_pullup_we, i_phase_cnt_ch7_ch11, i_phase_cnt_ch8_ch10} = '0;
    {i_counter_clear_sel_ch6, i_prescaler_sel_ch6, i_prescaler_sel_ch7} = '0;
    {i_prescaler_sel_ch8, i_prescaler_sel_ch9, i_prescaler_sel_ch10} = '0;
    {i_prescaler_sel_ch11, i_counter_clear_sel_ch7} = '0;
    {i_counter_clear_sel_ch8, i_dir_wdata, i_pullup_wdata, i_gpio_out} = '0;
    {i_pin_in, i_timer_mode_reg_ch6, i_timer_mode_reg_ch7} = '0;
    {i_timer_mode_reg_ch8, i_timer_io_ctrl_hi_ch6} = '0;
    {i_timer_io_ctrl_lo_ch6, i_timer_io_ctrl_ch7, i_timer_io_ctrl_ch8} = '0;
    void'($urandom(16));
    repeat (11) @(posedge i_clk);
    #1 chk(o_pin_oe | o_pullup_on | o_capture_in_en, 8'h00);
    @(posedge i_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      apply(ml[k % 4], k[2], k == 6);
      settle;
      cmp(0, 0);
    end
    $display("test modes done");
    @(posedge i_clk);
    i_dir_we <= 1'b1;
    i_dir_wdata <= 8'haa;
    @(posedge i_clk);
    i_dir_wdata <= 8'h55;
    @(posedge i_clk);
    i_dir_we <= 1'b0;
    #1 chk(o_pin_oe, 8'haa);
    @(posedge i_clk);
    #1 chk(o_pin_oe, 8'h55);
    $display("test direction writes done");
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1 chk(o_pullup_on | o_pin_oe, 8'h00);
    @(posedge i_clk);
    i_rst <= 1'b0;
    dir = 0;
    pu = 0;
    settle;
    cmp(0, 0);
    $display("test reset done");
    tcase(8'h00, 8'h73, 8'h40, 3'h0, 8'h00, 8'h21, 2'h0, 8'hf3, 0);
    tcase(8'h00, 8'h86, 8'h57, 3'h0, 8'h00, 8'h04, 2'h0, 8'h0d, 8'h02);
    tcase(8'h00, 8'h9a, 8'hb8, 3'h0, 8'h04, 8'hc9, 2'h0, 0, 8'hdf);
    tcase(8'h04, 8'h9a, 8'hb8, 3'h0, 8'h00, 8'h88, 2'h0, 0, 8'hf0);
    tcase(8'h02, 8'h11, 8'h02, 3'h0, 8'h02, 8'h13, 2'h0, 8'h55, 0);
    tcase(8'h12, 8'h11, 8'h22, 3'h0, 8'h02, 8'h00, 2'h0, 8'h01, 0);
    tcase(8'h23, 8'h11, 8'h11, 3'h5, 8'h03, 8'h11, 2'h0, 8'hf3, 0);
    tcase(8'h03, 8'h11, 8'h11, 3'h1, 8'h03, 8'h11, 2'h2, 8'h5e, 0);
    tcase(8'h03, 8'h11, 8'h11, 3'h6, 8'h03, 8'h11, 2'h1, 8'ha7, 0);
    tcase(8'h03, 8'h66, 8'h66, 3'h2, 8'h03, 8'h00, 2'h0, 8'h0d, 0);
    tcase(8'h03, 8'h55, 8'h55, 3'h5, 8'h03, 8'h00, 2'h0, 8'h0b, 0);
    $display("test timer functions done");
    for (int i = 0; i < 16; i++) begin
      clk_case(i);
    end
    $display("test external clocks done");
    stop_test;
  end
endmodule : tb_pbps_port_b
